//--- sac_regs.svh
// register map, reset values and timing constants of the converter control block
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SAC_ADDR_MODE 16'hff80
`define SAC_ADDR_CHAN 16'hff84
`define SAC_ADDR_RESULT 16'hff88
`define SAC_ADDR_FLAG 16'hff8c

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define SAC_REG_W 8
`define SAC_MODE_RST 8'h00
`define SAC_MODE_MASK 8'hb8
`define SAC_CHAN_RST 2'h0
`define SAC_RESULT_RST 8'h00
`define SAC_FLAG_CLR_BIT 0

// ----------------------------------------------------------------
// conversion time codes and their lengths in system clocks
// ----------------------------------------------------------------
`define SAC_CT_144 3'h0
`define SAC_CT_120 3'h4
`define SAC_CT_96 3'h2
`define SAC_CT_72 3'h6
`define SAC_CT_60 3'h5
`define SAC_CT_48 3'h3
`define SAC_LEN_144 8'h90
`define SAC_LEN_120 8'h78
`define SAC_LEN_96 8'h60
`define SAC_LEN_72 8'h48
`define SAC_LEN_60 8'h3c
`define SAC_LEN_48 8'h30

// ----------------------------------------------------------------
// sequencing: 4 sampling steps then 8 comparison steps
// ----------------------------------------------------------------
`define SAC_STEPS_PER_CONV 8'h0c
`define SAC_SAMPLE_LAST 4'h3
`define SAC_SAR_MSB 3'h7
`define SAC_SAR_FIRST 8'h80
`define SAC_CLK_PERIOD_NS 100
`define SAC_MIN_CONV_NS 14000
`define SAC_MIN_CONV_CYC ((`SAC_MIN_CONV_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

`endif

//--- sac_pkg.sv
// types shared by the converter control block
package sac_pkg;

    // mode register layout
    typedef struct packed {
        logic enable;
        logic rsv6;
        logic [2:0] ctime;
        logic [2:0] rsv;
    } sac_mode_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        SAC_IDLE = 3'b001,
        SAC_SAMPLE = 3'b010,
        SAC_CONV = 3'b100
    } sac_state_t;

endpackage

//--- sac_step_timer.sv
// step timer: one-cycle tick every period_i clocks while running
module sac_step_timer (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic restart_i,
    input wire logic run_i,
    input wire logic [7:0] period_i,
    output logic tick_o
);

    logic [7:0] cnt_q;

    // down counter; restart realigns so a fresh conversion gets full steps
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 8'h00;
            tick_o <= 1'b0;
        end else if (restart_i || !run_i) begin
            cnt_q <= 8'(period_i - 8'h01);
            tick_o <= 1'b0;
        end else if (cnt_q == 8'h00) begin
            cnt_q <= 8'(period_i - 8'h01);
            tick_o <= 1'b1;
        end else begin
            cnt_q <= 8'(cnt_q - 8'h01);
            tick_o <= 1'b0;
        end
    end

endmodule

//--- sac_sar.sv
// successive-approximation register: one bit decided per step, msb first
`include "sac_regs.svh"
module sac_sar (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic step_i,
    input wire logic comp_i,
    output logic [7:0] code_o,
    output logic last_o,
    output logic done_o
);

    logic busy_q;
    logic [2:0] idx_q;
    logic [7:0] trial;

    // keep or drop the bit under test, then raise the next one
    always_comb begin
        trial = code_o;
        if (!comp_i) begin
            trial[idx_q] = 1'b0;
        end
        if (idx_q != 3'h0) begin
            trial[3'(idx_q - 3'h1)] = 1'b1;
        end
    end

    assign last_o = busy_q && (idx_q == 3'h0);

    // done fires the cycle after bit 0 is decided; the result stays on code_o
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_q <= 1'b0;
            idx_q <= 3'h0;
            code_o <= 8'h00;
            done_o <= 1'b0;
        end else if (abort_i) begin
            busy_q <= 1'b0;
            done_o <= 1'b0;
        end else if (start_i) begin
            busy_q <= 1'b1;
            idx_q <= `SAC_SAR_MSB;
            code_o <= `SAC_SAR_FIRST;
            done_o <= 1'b0;
        end else if (busy_q && step_i) begin
            code_o <= trial;
            idx_q <= 3'(idx_q - 3'h1);
            busy_q <= (idx_q != 3'h0);
            done_o <= (idx_q == 3'h0);
        end else begin
            done_o <= 1'b0;
        end
    end

endmodule

//--- sac_adc_ctrl.sv
// digital control of a four-channel 8-bit successive-approximation converter
`include "sac_regs.svh"
module sac_adc_ctrl (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic standby_i,
    input wire logic comp_i,
    output logic sample_o,
    output logic [7:0] tap_code_o,
    output logic [3:0] ain_sel_o,
    output logic conversion_end_irq_o,
    output logic conversion_end_flag_o
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    sac_pkg::sac_mode_t converter_mode_reg_q;
    sac_pkg::sac_mode_t mode_nx;
    sac_pkg::sac_state_t state_q;
    sac_pkg::sac_state_t state_d;
    logic [1:0] channel_select_reg_q;
    logic [7:0] conv_result_reg_q;
    logic [3:0] phase_q;
    logic [2:0] comp_sync_q;
    logic comp_q;
    logic setup;
    logic access;
    logic mapped;
    logic wr_mode;
    logic wr_chan;
    logic wr_flag;
    logic ctl_wr;
    logic wr_enable;
    logic restart;
    logic sar_start;
    logic sar_abort;
    logic sar_last;
    logic sar_done;
    logic tick;
    logic conv_end;
    logic [7:0] step_len;
    logic [31:0] rd_mux;

    // conversion length for a time code; prohibited or too short falls back to longest
    function automatic logic [7:0] conv_len(input logic [2:0] ct);
        logic [7:0] len;
        len = `SAC_LEN_144;
        unique case (ct)
            `SAC_CT_144: len = `SAC_LEN_144;
            `SAC_CT_120: len = `SAC_LEN_120;
            `SAC_CT_96: len = `SAC_LEN_96;
            `SAC_CT_72: len = `SAC_LEN_72;
            `SAC_CT_60: len = `SAC_LEN_60;
            `SAC_CT_48: len = `SAC_LEN_48;
            default: len = `SAC_LEN_144;
        endcase
        if (len < 8'(`SAC_MIN_CONV_CYC)) begin
            len = `SAC_LEN_144;
        end
        return len;
    endfunction

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign setup = psel_i && !penable_i && !pready_o;
    assign access = psel_i && penable_i && pready_o;
    assign mapped = (paddr_i == `SAC_ADDR_MODE) || (paddr_i == `SAC_ADDR_CHAN) ||
                    (paddr_i == `SAC_ADDR_RESULT) || (paddr_i == `SAC_ADDR_FLAG);
    assign wr_mode = access && pwrite_i && (paddr_i == `SAC_ADDR_MODE);
    assign wr_chan = access && pwrite_i && (paddr_i == `SAC_ADDR_CHAN);
    assign wr_flag = access && pwrite_i && (paddr_i == `SAC_ADDR_FLAG);
    assign ctl_wr = wr_mode || wr_chan;

    // read mux; reserved bits read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr_i)
            `SAC_ADDR_MODE: rd_mux = {24'h00_0000, converter_mode_reg_q};
            `SAC_ADDR_CHAN: rd_mux = {30'h0000_0000, channel_select_reg_q};
            `SAC_ADDR_RESULT: rd_mux = {24'h00_0000, conv_result_reg_q};
            `SAC_ADDR_FLAG: rd_mux = {31'h0000_0000, conversion_end_flag_o};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // one access cycle, no waits; read data is captured at the setup edge, so a
    // result loaded at that same edge is seen only by the next read
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (setup) begin
            pready_o <= 1'b1;
            pslverr_o <= !mapped;
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_comb begin
        mode_nx = converter_mode_reg_q;
        if (wr_mode) begin
            mode_nx = sac_pkg::sac_mode_t'(pwdata_i[`SAC_REG_W-1:0] & `SAC_MODE_MASK);
        end
    end

    // mode register, zero after reset
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            converter_mode_reg_q <= sac_pkg::sac_mode_t'(`SAC_MODE_RST);
        end else begin
            converter_mode_reg_q <= mode_nx;
        end
    end

    // channel register with registered one-hot input select
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            channel_select_reg_q <= `SAC_CHAN_RST;
            ain_sel_o <= 4'h1;
        end else if (wr_chan) begin
            channel_select_reg_q <= pwdata_i[1:0];
            ain_sel_o <= 4'(4'h1 << pwdata_i[1:0]);
        end
    end

    // ----------------------------------------------------------------
    // comparator input synchroniser
    // ----------------------------------------------------------------
    // the first stage is read only by the second; a change counts once two agree
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            comp_sync_q <= 3'h0;
            comp_q <= 1'b0;
        end else begin
            comp_sync_q <= {comp_sync_q[1:0], comp_i};
            if (comp_sync_q[1] == comp_sync_q[2]) begin
                comp_q <= comp_sync_q[2];
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    assign wr_enable = wr_mode ? mode_nx.enable : converter_mode_reg_q.enable;
    assign step_len = 8'(conv_len(mode_nx.ctime) / `SAC_STEPS_PER_CONV);

    // standby beats everything, then a control write, then normal stepping
    always_comb begin
        state_d = state_q;
        restart = 1'b0;
        sar_start = 1'b0;
        if (standby_i) begin
            state_d = sac_pkg::SAC_IDLE;
        end else if (ctl_wr) begin
            if (wr_enable) begin
                state_d = sac_pkg::SAC_SAMPLE;
                restart = 1'b1;
            end else begin
                state_d = sac_pkg::SAC_IDLE;
            end
        end else begin
            unique case (state_q)
                sac_pkg::SAC_IDLE: begin
                    if (converter_mode_reg_q.enable) begin
                        state_d = sac_pkg::SAC_SAMPLE;
                        restart = 1'b1;
                    end
                end
                sac_pkg::SAC_SAMPLE: begin
                    if (tick && phase_q == `SAC_SAMPLE_LAST) begin
                        state_d = sac_pkg::SAC_CONV;
                        sar_start = 1'b1;
                    end
                end
                sac_pkg::SAC_CONV: begin
                    if (tick && sar_last) begin
                        state_d = sac_pkg::SAC_SAMPLE;
                    end
                end
                default: state_d = sac_pkg::SAC_IDLE;
            endcase
        end
    end

    // state and the sample/hold control that follows it
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= sac_pkg::SAC_IDLE;
            sample_o <= 1'b0;
        end else begin
            state_q <= state_d;
            sample_o <= (state_d == sac_pkg::SAC_SAMPLE);
        end
    end

    // sampling step counter; held at zero outside sampling
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_q <= 4'h0;
        end else if (restart || state_q != sac_pkg::SAC_SAMPLE) begin
            phase_q <= 4'h0;
        end else if (tick) begin
            phase_q <= 4'(phase_q + 4'h1);
        end
    end

    assign sar_abort = restart || (state_d == sac_pkg::SAC_IDLE);

    sac_step_timer u_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .restart_i(restart),
        .run_i(state_d != sac_pkg::SAC_IDLE),
        .period_i(step_len),
        .tick_o(tick)
    );

    // taps are offset half a step down in the resistor string, so the code rounds
    sac_sar u_sar (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(sar_start),
        .abort_i(sar_abort),
        .step_i(tick),
        .comp_i(comp_q),
        .code_o(tap_code_o),
        .last_o(sar_last),
        .done_o(sar_done)
    );

    // ----------------------------------------------------------------
    // result, end request and flag
    // ----------------------------------------------------------------
    // a control write in the end cycle wins: result and request are dropped
    assign conv_end = sar_done && !ctl_wr;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            conv_result_reg_q <= `SAC_RESULT_RST;
            conversion_end_irq_o <= 1'b0;
        end else begin
            if (conv_end) begin
                conv_result_reg_q <= tap_code_o;
            end
            conversion_end_irq_o <= conv_end;
        end
    end

    // sticky flag: set wins over a clear; mode writes never touch it
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            conversion_end_flag_o <= 1'b0;
        end else if (conv_end) begin
            conversion_end_flag_o <= 1'b1;
        end else if (wr_flag && pwdata_i[`SAC_FLAG_CLR_BIT]) begin
            conversion_end_flag_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence mode_wr_on_s;
        wr_mode && mode_nx.enable && !standby_i;
    endsequence

    sequence fresh_sample_s;
        state_q == sac_pkg::SAC_SAMPLE && phase_q == 4'h0 && sample_o;
    endsequence

    // length helper: cycles since the last end, parked at all ones after any break
    logic [7:0] gap_q;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            gap_q <= 8'hff;
        end else if (sar_abort || sar_done) begin
            gap_q <= sar_abort ? 8'hff : 8'h01;
        end else if (gap_q != 8'hff) begin
            gap_q <= 8'(gap_q + 8'h01);
        end
    end

    runs_enabled_a: assert property (
        state_q != sac_pkg::SAC_IDLE |-> converter_mode_reg_q.enable
    ) else $error("converter runs with enable clear");
    result_load_a: assert property (
        conversion_end_irq_o |-> conv_result_reg_q == $past(tap_code_o) && conversion_end_flag_o
    ) else $error("end request without result load");
    repeat_conv_a: assert property (
        $rose(conversion_end_irq_o) && converter_mode_reg_q.enable && !standby_i && !$past(ctl_wr)
        |-> state_q == sac_pkg::SAC_SAMPLE
    ) else $error("no new conversion after end");

    restart_a: assert property (
        mode_wr_on_s |=> fresh_sample_s
    ) else $error("enable write did not restart");
    stop_a: assert property (
        wr_mode && !mode_nx.enable |=> state_q == sac_pkg::SAC_IDLE && !sample_o
    ) else $error("disable write did not stop");
    standby_halt_a: assert property (
        standby_i |=> state_q == sac_pkg::SAC_IDLE ##1 !tick
    ) else $error("converter runs in standby");

    read_old_a: assert property (
        setup && !pwrite_i && paddr_i == `SAC_ADDR_RESULT && conv_end
        |=> prdata_o[7:0] == $past(conv_result_reg_q) && conv_result_reg_q == $past(tap_code_o)
    ) else $error("read did not return old result");
    write_wins_a: assert property (
        sar_done && ctl_wr |=> !conversion_end_irq_o && $stable(conv_result_reg_q)
    ) else $error("result loaded despite control write");

    flag_kept_a: assert property (
        wr_mode && conversion_end_flag_o |=> conversion_end_flag_o
    ) else $error("mode write cleared end flag");
    conv_len_a: assert property (
        sar_done && gap_q != 8'hff |-> gap_q == conv_len(converter_mode_reg_q.ctime)
    ) else $error("conversion length differs from selected time");

    irq_pulse_a: assert property (
        conversion_end_irq_o |=> !conversion_end_irq_o [*3]
    ) else $error("end request longer than one cycle");

endmodule

//--- sac_analog_model.sv
// analog front-end model: input levels, sample/hold and comparator
module sac_analog_model (
    input wire logic sample_i,
    input wire logic [7:0] tap_code_i,
    input wire logic [3:0] ain_sel_i,
    input wire logic [9:0] vin_i [4],
    output logic comp_o
);
    // ------------------------------------------------------------
    // input selection and hold
    // ------------------------------------------------------------
    logic [9:0] held_q;
    logic [9:0] sel_v;

    initial held_q = 10'h000;

    // a bad select gives a changing junk level, never a clean copy
    always_comb begin
        sel_v = held_q ^ 10'h2aa;
        for (int k = 0; k < 4; k++) begin
            if (ain_sel_i == (4'h1 << k)) sel_v = vin_i[k];
        end
    end

    // the hold capacitor tracks while sampling, keeps its level after;
    // no port input reads are modelled on the selected pin, so the level stays clean
    always @(sample_i or sel_v) begin
        if (sample_i) held_q = sel_v;
    end

    // ------------------------------------------------------------
    // comparator
    // ------------------------------------------------------------
    // levels are in 1/1024 of supply; taps sit half a step below each code
    assign comp_o = ({1'b0, held_q} + 11'h002) >= {1'b0, tap_code_i, 2'b00};
endmodule

//--- tb_sac_adc_ctrl.sv
// self-checking bench for the converter control block
`include "sac_regs.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] t=%0t got %h expected %h", $time, got, exp); end end
module tb_sac_adc_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [15:0] paddr_i = 16'h0000;
    logic [31:0] pwdata_i = 32'h0;
    logic standby_i = 1'b0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, comp_i, sample_o, conversion_end_irq_o, conversion_end_flag_o;
    logic [7:0] tap_code_o;
    logic [3:0] ain_sel_o;
    logic [9:0] vin [4];
    logic [32:0] exp_q [$];
    logic [32:0] e_now;
    logic [7:0] old_code;
    logic [2:0] ct [7] = '{`SAC_CT_144, `SAC_CT_120, `SAC_CT_96, `SAC_CT_72,
                           `SAC_CT_60, `SAC_CT_48, 3'h7};
    int fails = 0;
    int n_tests = 0;
    int irq_cnt = 0;
    int cnt = 0;
    int seed = 20;
    int cyc = 0;
    int last_irq = 0;
    int period = 0;

    always #50 clk_i = ~clk_i;

    sac_adc_ctrl dut_u (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .standby_i(standby_i), .comp_i(comp_i), .sample_o(sample_o),
        .tap_code_o(tap_code_o), .ain_sel_o(ain_sel_o),
        .conversion_end_irq_o(conversion_end_irq_o),
        .conversion_end_flag_o(conversion_end_flag_o));

    sac_analog_model model_u (.sample_i(sample_o), .tap_code_i(tap_code_o),
        .ain_sel_i(ain_sel_o), .vin_i(vin), .comp_o(comp_i));

    // ------------------------------------------------------------
    // bus driver and monitor
    // ------------------------------------------------------------
    // one transfer plus an idle cycle, so psel is never assigned twice in a step
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exp_q.push_back(e);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [15:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 33'h0);
    endtask

    // every completed access takes the oldest note off the queue
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1) begin
            e_now = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
            `CHK(pslverr_o, e_now[32])
            if (!pwrite_i) `CHK(prdata_o, e_now[31:0])
        end
    end

    // end pulses are counted and their spacing measured
    always @(posedge clk_i) begin
        cyc++;
        if (conversion_end_irq_o === 1'b1) begin
            irq_cnt++;
            period = cyc - last_irq;
            last_irq = cyc;
        end
    end

    task automatic wait_irq(input int n);
        int t;
        t = irq_cnt + n;
        while (irq_cnt < t) @(posedge clk_i);
    endtask

    // levels near full scale round up past the top code and clip
    function automatic logic [7:0] code_of(input logic [9:0] v);
        return (v > 10'h3fd) ? 8'hff : 8'((v + 10'h002) >> 2);
    endfunction

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        for (int k = 0; k < 4; k++) vin[k] = 10'($random(seed));
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        `CHK(ain_sel_o, 4'h1)
        rd(`SAC_ADDR_MODE, 33'h0);
        rd(`SAC_ADDR_CHAN, 33'h0);
        rd(`SAC_ADDR_FLAG, 33'h0);
        rd(16'hff90, {1'b1, 32'h0});
        wr(`SAC_ADDR_RESULT, 8'h5a);
        rd(`SAC_ADDR_RESULT, 33'h0);
        repeat (300) @(posedge clk_i);
        `CHK(irq_cnt, 0)
        $display("test reset and map done");
        // each defined time code plus prohibited code 7, channels in turn; the first result is thrown away
        for (int k = 0; k < 7; k++) begin
            wr(`SAC_ADDR_CHAN, 8'(k % 4));
            `CHK(ain_sel_o, 4'h1 << (k % 4))
            wr(`SAC_ADDR_FLAG, 8'h01);
            wr(`SAC_ADDR_MODE, {2'b10, ct[k], 3'h0});
            wait_irq(2);
            `CHK(period, 144)
            rd(`SAC_ADDR_RESULT, {25'h0, code_of(vin[k % 4])});
            rd(`SAC_ADDR_FLAG, 33'h1);
            rd(`SAC_ADDR_MODE, {25'h0, 2'b10, ct[k], 3'h0});
        end
        $display("test time codes and channels done");
        // clearing enable stops for good; the flag survives the write
        wr(`SAC_ADDR_MODE, 8'h00);
        rd(`SAC_ADDR_FLAG, 33'h1);
        `CHK(conversion_end_flag_o, 1'b1)
        cnt = irq_cnt;
        repeat (400) @(posedge clk_i);
        `CHK(irq_cnt, cnt)
        `CHK(sample_o, 1'b0)
        $display("test stop done");
        // a second enabling write abandons the conversion under way
        wr(`SAC_ADDR_FLAG, 8'h01);
        wr(`SAC_ADDR_MODE, 8'h80);
        repeat (100) @(posedge clk_i);
        wr(`SAC_ADDR_MODE, 8'h80);
        cnt = irq_cnt;
        repeat (120) @(posedge clk_i);
        `CHK(irq_cnt, cnt)
        wait_irq(1);
        $display("test restart done");
        // standby halts, release resumes
        standby_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        cnt = irq_cnt;
        repeat (400) @(posedge clk_i);
        `CHK(irq_cnt, cnt)
        standby_i <= 1'b0;
        wait_irq(2);
        $display("test standby done");
        // a read whose capture edge meets the load returns the old code
        old_code = code_of(vin[2]);
        do @(posedge clk_i); while (conversion_end_irq_o !== 1'b1);
        vin[2] = ~vin[2];
        repeat (142) @(posedge clk_i);
        rd(`SAC_ADDR_RESULT, {25'h0, old_code});
        rd(`SAC_ADDR_RESULT, {25'h0, code_of(vin[2])});
        // a channel write whose access edge meets the next load drops result and request
        vin[2] = ~vin[2];
        repeat (137) @(posedge clk_i);
        cnt = irq_cnt;
        wr(`SAC_ADDR_CHAN, 8'h02);
        rd(`SAC_ADDR_RESULT, {25'h0, code_of(~vin[2])});
        `CHK(irq_cnt, cnt)
        $display("test read collision done");
        wr(`SAC_ADDR_MODE, 8'h00);
        conclude();
    end

    // hang guard, far beyond the roughly 4300 cycles the run needs
    initial begin
        #2000000;
        fails++;
        conclude();
    end
endmodule
